// >>> scm_pkg.sv
// Overview of operation
// R1: Four programmable match pattern registers.
// R2: Eight-bit patterns; all bits compared.
// R3: Software zeroes unused pattern bits.
// R4: Pattern one is XON, two XOFF.
// R5: Range check only when option bit 7 set.
// R6: In range means lower <= char <= upper.
// R7: In-range character posts special detect request.
// R8: Range detect sets status bits 6:4 to 111.
// R9: Range check runs beside pattern matching.
// R10: Upper and lower bounds are inclusive.
// R11: Range enable clear never posts range detect.
package scm_pkg;
   localparam int unsigned ADDR_W    = 12;
   localparam int unsigned IDX_W     = 10;
   localparam int unsigned CHAR_W    = 8;
   localparam int unsigned NUM_PAT   = 4;
   localparam int unsigned EVT_W     = 5;
   // Register indices; byte address is four times the index.
   localparam logic [9:0] IDX_MATCH1 = 10'h01a;
   localparam logic [9:0] IDX_MATCH2 = 10'h01b;
   localparam logic [9:0] IDX_MATCH3 = 10'h01c;
   localparam logic [9:0] IDX_MATCH4 = 10'h01d;
   localparam logic [9:0] IDX_RANGE_LO = 10'h022;
   localparam logic [9:0] IDX_RANGE_HI = 10'h023;
   localparam logic [9:0] IDX_OPT3   = 10'h030;
   localparam logic [9:0] IDX_RX_STATUS = 10'h031;
   localparam logic [9:0] IDX_EVT    = 10'h032;
   localparam logic [9:0] IDX_MASK   = 10'h033;
   // Field positions and codes.
   localparam int unsigned OPT3_RANGE_EN = 7;
   localparam int unsigned EVT_RANGE     = 4;
   localparam logic [2:0]  CODE_NONE     = 3'h0;
   localparam logic [2:0]  CODE_RANGE    = 3'h7;
   localparam logic [7:0]  CHAR_RESET    = 8'h00;
   localparam logic [4:0]  EVT_RESET     = 5'h00;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } scm_rx_s;

   typedef struct packed {
      logic [3:0] match;
      logic       range_hit;
      logic       xon;
      logic       xoff;
      logic [2:0] code;
   } scm_hit_s;
endpackage : scm_pkg

// >>> scm_match.sv
// Implementation choice: the AXI4-Lite register port.
module scm_match (
   // Clock and reset.
   input  wire  logic             aclk,
   input  wire  logic             aresetn,
   // Write address channel.
   input  wire  logic [11:0]      awaddr,
   input  wire  logic [2:0]       awprot,
   input  wire  logic             awvalid,
   output logic                   awready,
   // Write data channel.
   input  wire  logic [31:0]      wdata,
   input  wire  logic [3:0]       wstrb,
   input  wire  logic             wvalid,
   output logic                   wready,
   // Write response channel.
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire  logic             bready,
   // Read address channel.
   input  wire  logic [11:0]      araddr,
   input  wire  logic [2:0]       arprot,
   input  wire  logic             arvalid,
   output logic                   arready,
   // Read data channel.
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire  logic             rready,
   // Received characters from the receiver.
   input  wire  scm_pkg::scm_rx_s rx,
   // Detection results and interrupt.
   output scm_pkg::scm_hit_s      hit,
   output logic                   irq
);

   logic [7:0]  pat [scm_pkg::NUM_PAT];
   logic [7:0]  range_lower_bound;
   logic [7:0]  range_upper_bound;
   logic [7:0]  channel_option_three;
   logic [7:0]  receive_data_status;
   logic [4:0]  evt;
   logic [4:0]  mask;
   logic        aw_held;
   logic        w_held;
   logic [9:0]  aw_idx;
   logic [7:0]  wbyte;
   logic        wlane0;
   logic        do_wr;
   logic        wr_ok;
   logic        ar_take;
   logic [9:0]  ar_idx;
   logic [7:0]  rd_byte;
   logic        rd_ok;
   logic        rd_clr;
   logic [3:0]  eq;
   logic        range_en;
   logic        in_rng;
   logic [2:0]  next_code;
   logic [4:0]  next_evt;

   // Write side: address and data are taken independently and held.
   assign awready = !aw_held && !bvalid;
   assign wready  = !w_held && !bvalid;
   assign do_wr   = aw_held && w_held && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_idx  <= 10'h000;
      end else if (do_wr) begin
         aw_held <= 1'b0;
      end else if (awvalid && awready) begin
         aw_held <= 1'b1;
         aw_idx  <= awaddr[11:2];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         wbyte  <= 8'h00;
         wlane0 <= 1'b0;
      end else if (do_wr) begin
         w_held <= 1'b0;
      end else if (wvalid && wready) begin
         w_held <= 1'b1;
         wbyte  <= wdata[7:0];
         wlane0 <= wstrb[0];
      end
   end

   // Unmapped addresses answer with a slave error and change nothing.
   always_comb begin
      unique case (aw_idx)
         scm_pkg::IDX_MATCH1, scm_pkg::IDX_MATCH2,
         scm_pkg::IDX_MATCH3, scm_pkg::IDX_MATCH4,
         scm_pkg::IDX_RANGE_LO, scm_pkg::IDX_RANGE_HI,
         scm_pkg::IDX_OPT3, scm_pkg::IDX_RX_STATUS,
         scm_pkg::IDX_EVT, scm_pkg::IDX_MASK: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= scm_pkg::RESP_OKAY;
      end else if (do_wr) begin
         bvalid <= 1'b1;
         bresp  <= wr_ok ? scm_pkg::RESP_OKAY : scm_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Writable registers; all bits except mask bits 7:5 are stored and read back as written.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int k = 0; k < scm_pkg::NUM_PAT; k++) begin
            pat[k] <= scm_pkg::CHAR_RESET; // [R1]
         end
         range_lower_bound    <= scm_pkg::CHAR_RESET;
         range_upper_bound    <= scm_pkg::CHAR_RESET;
         channel_option_three <= scm_pkg::CHAR_RESET;
         mask                 <= scm_pkg::EVT_RESET;
      end else if (do_wr && wlane0) begin
         case (aw_idx)
            scm_pkg::IDX_MATCH1:   pat[0] <= wbyte; // [R1] [R4]
            scm_pkg::IDX_MATCH2:   pat[1] <= wbyte; // [R1] [R4]
            scm_pkg::IDX_MATCH3:   pat[2] <= wbyte; // [R1]
            scm_pkg::IDX_MATCH4:   pat[3] <= wbyte; // [R1]
            scm_pkg::IDX_RANGE_LO: range_lower_bound <= wbyte; // [R10]
            scm_pkg::IDX_RANGE_HI: range_upper_bound <= wbyte; // [R10]
            scm_pkg::IDX_OPT3:     channel_option_three <= wbyte; // [R5]
            scm_pkg::IDX_MASK:     mask <= wbyte[4:0];
            default: ;
         endcase
      end
   end

   // Read side: the answer is registered in the cycle the address is taken.
   assign arready = !rvalid;
   assign ar_take = arvalid && arready;
   assign ar_idx  = araddr[11:2];
   assign rd_clr  = ar_take && (ar_idx == scm_pkg::IDX_EVT);

   always_comb begin
      rd_ok = 1'b1;
      unique case (ar_idx)
         scm_pkg::IDX_MATCH1:   rd_byte = pat[0];
         scm_pkg::IDX_MATCH2:   rd_byte = pat[1];
         scm_pkg::IDX_MATCH3:   rd_byte = pat[2];
         scm_pkg::IDX_MATCH4:   rd_byte = pat[3];
         scm_pkg::IDX_RANGE_LO:  rd_byte = range_lower_bound;
         scm_pkg::IDX_RANGE_HI:  rd_byte = range_upper_bound;
         scm_pkg::IDX_OPT3:      rd_byte = channel_option_three;
         scm_pkg::IDX_RX_STATUS: rd_byte = receive_data_status;
         scm_pkg::IDX_EVT:      rd_byte = {3'h0, evt};
         scm_pkg::IDX_MASK:     rd_byte = {3'h0, mask};
         default: begin
            rd_byte = 8'h00;
            rd_ok   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= scm_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rvalid <= 1'b1;
         rdata  <= {24'h00_0000, rd_byte};
         rresp  <= rd_ok ? scm_pkg::RESP_OKAY : scm_pkg::RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // Pattern comparison uses every bit, so stray high bits never match.
   for (genvar k = 0; k < scm_pkg::NUM_PAT; k++) begin : g_cmp
      assign eq[k] = rx.valid && (rx.data == pat[k]); // [R2] [R1]
   end

   // Range window runs on its own, beside the pattern compare.
   assign range_en = channel_option_three[scm_pkg::OPT3_RANGE_EN]; // [R5]
   assign in_rng   = rx.valid && range_en // [R5] [R11] [R9]
                     && (rx.data >= range_lower_bound) // [R6] [R10]
                     && (rx.data <= range_upper_bound); // [R6] [R10]

   // A range hit outranks a pattern hit in the status code field.
   always_comb begin
      if (in_rng) begin
         next_code = scm_pkg::CODE_RANGE; // [R8]
      end else if (eq[0]) begin
         next_code = 3'h1;
      end else if (eq[1]) begin
         next_code = 3'h2;
      end else if (eq[2]) begin
         next_code = 3'h3;
      end else if (eq[3]) begin
         next_code = 3'h4;
      end else begin
         next_code = scm_pkg::CODE_NONE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hit <= '0;
      end else begin
         hit.match     <= eq; // [R9]
         hit.range_hit <= in_rng; // [R7]
         hit.xon       <= eq[0]; // [R4]
         hit.xoff      <= eq[1]; // [R4]
         hit.code      <= next_code;
      end
   end

   // The status keeps the last exception until the next one arrives.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receive_data_status <= scm_pkg::CHAR_RESET;
      end else if (in_rng || (|eq)) begin
         receive_data_status <= {1'b0, next_code, 4'h0}; // [R8]
      end
   end

   // Sticky events; a new event in the clearing cycle survives the read.
   assign next_evt = {in_rng, eq};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt <= scm_pkg::EVT_RESET;
      end else begin
         evt <= (evt & ~{5{rd_clr}}) | next_evt; // [R7]
      end
   end

   assign irq = |(evt & mask);

   default clocking cb @(posedge aclk);
   endclocking

   default disable iff (!aresetn);

   a_range_post: assert property ( // [R7]
      rx.valid && range_en && rx.data >= range_lower_bound && rx.data <= range_upper_bound
      |=> hit.range_hit && evt[scm_pkg::EVT_RANGE])
      else $error("In-range character did not post a range hit.");

   a_range_gate: assert property ( // [R11]
      hit.range_hit |-> $past(range_en))
      else $error("Range hit posted while range check was off.");

   a_range_window: assert property ( // [R6]
      hit.range_hit |-> $past(rx.data) >= $past(range_lower_bound)
                        && $past(rx.data) <= $past(range_upper_bound))
      else $error("Range hit outside the programmed window.");

   a_range_code: assert property ( // [R8]
      hit.range_hit |-> receive_data_status[6:4] == scm_pkg::CODE_RANGE && hit.code == scm_pkg::CODE_RANGE)
      else $error("Range hit without code 111 in status.");

   a_bound_edges: assert property ( // [R10]
      rx.valid && range_en && (rx.data == range_lower_bound || rx.data == range_upper_bound)
      && range_lower_bound <= range_upper_bound |=> hit.range_hit)
      else $error("Inclusive bound value was not detected.");

   a_full_compare: assert property ( // [R2]
      rx.valid && rx.data != pat[2] |=> !hit.match[2])
      else $error("Pattern three matched an unequal character.");

   a_flow_chars: assert property ( // [R4]
      rx.valid && rx.data == pat[0] |=> hit.xon && hit.match[0])
      else $error("Pattern one did not flag the XON character.");

   a_both_checks: assert property ( // [R9]
      rx.valid && range_en && rx.data == pat[1] && rx.data >= range_lower_bound
      && rx.data <= range_upper_bound |=> hit.xoff && hit.range_hit)
      else $error("Range check suppressed the pattern match.");

   a_pat_store: assert property ( // [R1]
      do_wr && wlane0 && aw_idx == scm_pkg::IDX_MATCH4
      |=> pat[3] == $past(wbyte) ##1 !bvalid || pat[3] == $past(wbyte, 2))
      else $error("Pattern four did not take the written byte.");

   a_wr_answer: assert property ( // [R1]
      awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("Write response did not follow within two cycles.");

   a_rd_answer: assert property ( // [R1]
      ar_take |=> rvalid ##0 (rdata[31:8] == 24'h00_0000))
      else $error("Read answer missing or upper bits not zero.");

   a_evt_sticky: assert property ( // [R7]
      evt[0] && !rd_clr |=> evt[0])
      else $error("Sticky event dropped without a status read.");

   a_set_wins: assert property ( // [R7]
      rd_clr && eq[1] |=> evt[1])
      else $error("Event lost in the cycle its status was read.");

   a_gate_off: assert property ( // [R11]
      rx.valid && !range_en |=> !hit.range_hit && hit.code != scm_pkg::CODE_RANGE)
      else $error("Range hit posted while range check was disabled.");

   a_below_low: assert property ( // [R6]
      rx.valid && rx.data < range_lower_bound |=> !hit.range_hit)
      else $error("Character below the lower bound was flagged.");

   a_above_high: assert property ( // [R10]
      rx.valid && rx.data > range_upper_bound |=> !hit.range_hit)
      else $error("Character above the upper bound was flagged.");

   a_xoff_char: assert property ( // [R4]
      rx.valid && rx.data == pat[1] |=> hit.xoff && hit.match[1])
      else $error("Pattern two did not flag the XOFF character.");

   a_xon_exact: assert property ( // [R2]
      rx.valid && rx.data != pat[0] |=> !hit.xon)
      else $error("XON flagged for an unequal character.");

   a_match_four: assert property ( // [R1]
      rx.valid && rx.data == pat[3] |=> hit.match[3])
      else $error("Pattern four missed an equal character.");

   a_range_event: assert property ( // [R7]
      hit.range_hit |-> evt[scm_pkg::EVT_RANGE])
      else $error("Range hit did not set its sticky event.");

   a_irq_rise: assert property ( // [R7]
      (next_evt & mask) != 5'h00 && !do_wr |=> irq)
      else $error("Unmasked event did not raise the interrupt.");

   a_status_hold: assert property ( // [R8]
      !in_rng && eq == 4'h0 |=> $stable(receive_data_status))
      else $error("Status code changed without an exception.");

   a_bound_store: assert property ( // [R10]
      do_wr && wlane0 && aw_idx == scm_pkg::IDX_RANGE_LO |=> range_lower_bound == $past(wbyte))
      else $error("Lower bound did not take the written byte.");

   a_enable_store: assert property ( // [R5]
      do_wr && wlane0 && aw_idx == scm_pkg::IDX_OPT3
      |=> range_en == $past(wbyte[scm_pkg::OPT3_RANGE_EN]))
      else $error("Range enable did not follow the written bit.");

   a_read_clear: assert property ( // [R7]
      rd_clr && next_evt == 5'h00 |=> evt == 5'h00)
      else $error("Event status survived its read.");

   a_clear_data: assert property ( // [R7]
      rd_clr |=> rdata[4:0] == $past(evt))
      else $error("Event read did not return the events before clearing.");

endmodule : scm_match

// >>> scm_station.sv
module scm_station (
   // Clock and reset.
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Character request.
   input  wire logic        send,
   input  wire logic [7:0]  ch,
   // Received character strobe.
   output scm_pkg::scm_rx_s rx
);
   // Idle data toggles, so that a stale value can never pass for a character.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx <= '0;
      end else begin
         rx.valid <= send;
         rx.data  <= send ? ch : ~rx.data;
      end
   end
endmodule : scm_station

// >>> scm_match_bench.sv
module scm_match_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, send, rx_d;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, seed;
   logic [1:0] bresp, rresp;
   logic [7:0] ch, held_evt;
   logic [7:0] mdl [0:63];
   logic [33:0] bq [$], rq [$], hq [$];
   scm_pkg::scm_rx_s rx;
   scm_pkg::scm_hit_s hit;
   int error_cnt, check_count, cyc;

   scm_station i_scm_station (.aclk(aclk), .aresetn(aresetn), .send(send), .ch(ch), .rx(rx));
   scm_match i_scm_match (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rx(rx), .hit(hit), .irq(irq));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic mapped(input logic [9:0] idx);
      return idx inside {[scm_pkg::IDX_MATCH1:scm_pkg::IDX_MATCH4], scm_pkg::IDX_RANGE_LO,
                         scm_pkg::IDX_RANGE_HI, [scm_pkg::IDX_OPT3:scm_pkg::IDX_MASK]};
   endfunction : mapped

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic conclude();
      if (error_cnt == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      bq.push_back({32'h0, mapped(idx) ? scm_pkg::RESP_OKAY : scm_pkg::RESP_SLVERR});
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1)
            awvalid <= 1'b0;
         if (wvalid && wready === 1'b1)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      if (mapped(idx))
         mdl[idx] = d;
   endtask : wr

   task automatic rd(input logic [9:0] idx);
      logic [7:0] v;
      v = mapped(idx) ? mdl[idx] : 8'h00;
      if (idx == scm_pkg::IDX_EVT)
         mdl[idx] = 8'h00;
      rq.push_back({mapped(idx) ? scm_pkg::RESP_OKAY : scm_pkg::RESP_SLVERR, 24'h0, v});
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask : rd

   // Leaves the strobe high so that callers can send back to back; they lower it afterwards.
   task automatic send_ch(input logic [7:0] c);
      scm_pkg::scm_hit_s h;
      h = '0;
      for (int i = 0; i < 4; i++)
         h.match[i] = (c == mdl[scm_pkg::IDX_MATCH1 + i]);
      for (int i = 3; i >= 0; i--)
         if (h.match[i])
            h.code = 3'(i + 1);
      h.xon = h.match[0];
      h.xoff = h.match[1];
      h.range_hit = mdl[scm_pkg::IDX_OPT3][scm_pkg::OPT3_RANGE_EN] && c >= mdl[scm_pkg::IDX_RANGE_LO]
                    && c <= mdl[scm_pkg::IDX_RANGE_HI];
      if (h.range_hit)
         h.code = scm_pkg::CODE_RANGE;
      mdl[scm_pkg::IDX_EVT] = mdl[scm_pkg::IDX_EVT] | {3'h0, h.range_hit, h.match};
      if (h.code != scm_pkg::CODE_NONE)
         mdl[scm_pkg::IDX_RX_STATUS] = {1'b0, h.code, 4'h0};
      hq.push_back({23'h0, h, |(mdl[scm_pkg::IDX_EVT] & mdl[scm_pkg::IDX_MASK])});
      @(posedge aclk);
      send <= 1'b1;
      ch <= c;
   endtask : send_ch

   task automatic burst(input logic [7:0] cs [$]);
      foreach (cs[i])
         send_ch(cs[i]);
      @(posedge aclk);
      send <= 1'b0;
   endtask : burst

   always @(posedge aclk) begin
      if (bvalid === 1'b1 && bready === 1'b1)
         chk({32'h0, bresp}, bq.pop_front());
      if (rvalid === 1'b1 && rready === 1'b1)
         chk({rresp, rdata}, rq.pop_front());
      if (rx_d === 1'b1)
         chk({23'h0, hit, irq}, hq.pop_front());
      rx_d <= rx.valid;
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         error_cnt++;
         conclude();
      end
   end

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, send} = '0;
      {awaddr, araddr, wdata, ch} = '0;
      seed = 32'he1b2;
      mdl = '{default: 8'h00};
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (logic [9:0] a = 10'h01a; a <= 10'h033; a++)
         rd(a);
      rd(10'h3ff);
      wr(10'h3fe, 8'h55);
      wr(scm_pkg::IDX_MATCH1, 8'h11);
      wr(scm_pkg::IDX_MATCH2, 8'h13);
      wr(scm_pkg::IDX_MATCH3, 8'h91);
      wr(scm_pkg::IDX_MATCH4, 8'h41);
      wr(scm_pkg::IDX_RANGE_LO, 8'h40);
      wr(scm_pkg::IDX_RANGE_HI, 8'h5a);
      wr(scm_pkg::IDX_MASK, 8'h1f);
      burst('{8'h40, 8'h11, 8'h13, 8'h91, 8'h41, 8'h00});
      rd(scm_pkg::IDX_EVT);
      rd(scm_pkg::IDX_EVT);
      wr(scm_pkg::IDX_OPT3, 8'h80);
      burst('{8'h3f, 8'h40, 8'h5a, 8'h5b, 8'h41, 8'h11});
      rd(scm_pkg::IDX_RX_STATUS);
      burst('{8'h5a});
      rd(scm_pkg::IDX_RX_STATUS);
      rd(scm_pkg::IDX_EVT);
      wr(scm_pkg::IDX_MASK, 8'h10);
      fork
         begin
            send_ch(8'h13);
            @(posedge aclk);
            send <= 1'b0;
         end
         begin
            // The read clears in the cycle the character posts, so only the new event survives.
            @(posedge aclk);
            held_evt = mdl[scm_pkg::IDX_EVT];
            mdl[scm_pkg::IDX_EVT] = 8'h00;
            rd(scm_pkg::IDX_EVT);
            mdl[scm_pkg::IDX_EVT] = held_evt;
         end
      join
      rd(scm_pkg::IDX_EVT);
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         send_ch(seed[7:0]);
      end
      @(posedge aclk);
      send <= 1'b0;
      rd(scm_pkg::IDX_EVT);
      rd(scm_pkg::IDX_MASK);
      conclude();
   end
endmodule : scm_match_bench
